// *** logic/dspcg_clock_gate.v ***
// Deep-sleep port clock gate with its companion run and sleep registers
// Summary of operation
// - Set bit keeps port clocked in deep sleep
// - Clear bit stops and disables port
// - Access to gated port answers bus fault
// - Reset clears gating register to zero
// - Bits 0..7 gate ports A..H, read/write
// - Register at 0x128 governs deep sleep only
// - Sleep registers act only with auto gating
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "dspcg_map.vh"

module dspcg_clock_gate #(
    parameter PORTS = `DSPCG_PORT_BITS
) (
    // Clock and reset
    input  wire             clk_sys_i,
    input  wire             reset_n_i,
    // Register port
    input  wire [11:0]      reg_addr_i,
    input  wire [31:0]      reg_wdata_i,
    input  wire             reg_wr_i,
    input  wire             reg_rd_i,
    output reg  [31:0]      reg_rdata_o,
    // Power mode from the system controller
    input  wire             sleep_req_i,
    input  wire             deep_sleep_req_i,
    // Port clock enables
    output wire [PORTS-1:0] port_clk_en_o,
    // Port access checking
    input  wire             port_req_i,
    input  wire [2:0]       port_sel_i,
    output wire             port_fault_o,
    output wire             port_ok_o
);

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg  [PORTS-1:0] run_port_clock_enable_q;
    reg  [PORTS-1:0] sleep_port_clock_enable_q;
    reg  [PORTS-1:0] deep_sleep_port_clock_enable_q;
    reg              auto_gating_select_q;
    reg  [1:0]       mode_q;
    reg  [1:0]       mode_d;
    reg  [PORTS-1:0] clk_en_q;
    reg  [PORTS-1:0] clk_en_d;
    wire [7:0]       fault_count;

    function [31:0] dspcg_widen;
        input [PORTS-1:0] val;
        begin
            dspcg_widen = 32'h0000_0000;
            dspcg_widen[PORTS-1:0] = val;
        end
    endfunction

    // ****************************************************************
    // Register writes
    // ****************************************************************
    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            run_port_clock_enable_q        <= `DSPCG_PORT_EN_RESET;
            sleep_port_clock_enable_q      <= `DSPCG_PORT_EN_RESET;
            deep_sleep_port_clock_enable_q <= `DSPCG_PORT_EN_RESET;
            auto_gating_select_q           <= `DSPCG_CONFIG_RESET;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `DSPCG_OFS_RUN_PORT_EN: begin
                    run_port_clock_enable_q <= reg_wdata_i[PORTS-1:0];
                end
                `DSPCG_OFS_SLEEP_PORT_EN: begin
                    sleep_port_clock_enable_q <= reg_wdata_i[PORTS-1:0];
                end
                `DSPCG_OFS_DEEP_PORT_EN: begin
                    deep_sleep_port_clock_enable_q <= reg_wdata_i[PORTS-1:0];
                end
                `DSPCG_OFS_RUN_CLOCK_CONFIG: begin
                    auto_gating_select_q <= reg_wdata_i[`DSPCG_AUTO_GATING_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Register reads, upper bits read as zero
    // ****************************************************************
    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `DSPCG_OFS_RUN_PORT_EN:      reg_rdata_o <= dspcg_widen(run_port_clock_enable_q);
                `DSPCG_OFS_SLEEP_PORT_EN:    reg_rdata_o <= dspcg_widen(sleep_port_clock_enable_q);
                `DSPCG_OFS_DEEP_PORT_EN:     reg_rdata_o <= dspcg_widen(deep_sleep_port_clock_enable_q);
                `DSPCG_OFS_RUN_CLOCK_CONFIG: reg_rdata_o <= {4'h0, auto_gating_select_q, 27'h0};
                `DSPCG_OFS_MODE_STATUS:      reg_rdata_o <= {30'h0, mode_q};
                `DSPCG_OFS_FAULT_STATUS:     reg_rdata_o <= {24'h0, fault_count};
                default:                     reg_rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

    // ****************************************************************
    // Operating mode, deep sleep wins over sleep
    // ****************************************************************
    always @* begin
        if (deep_sleep_req_i) begin
            mode_d = `DSPCG_MODE_DEEP;
        end else if (sleep_req_i) begin
            mode_d = `DSPCG_MODE_SLEEP;
        end else begin
            mode_d = `DSPCG_MODE_RUN;
        end
    end

    // ****************************************************************
    // Effective port clock enables
    // ****************************************************************
    always @* begin
        case (mode_q)
            `DSPCG_MODE_SLEEP: begin
                clk_en_d = auto_gating_select_q ? sleep_port_clock_enable_q
                                                : run_port_clock_enable_q;
            end
            `DSPCG_MODE_DEEP: begin
                clk_en_d = auto_gating_select_q ? deep_sleep_port_clock_enable_q
                                                : run_port_clock_enable_q;
            end
            default: begin
                clk_en_d = run_port_clock_enable_q;
            end
        endcase
    end

    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            mode_q   <= `DSPCG_MODE_RUN;
            clk_en_q <= `DSPCG_PORT_EN_RESET;
        end else begin
            mode_q   <= mode_d;
            clk_en_q <= clk_en_d;
        end
    end

    assign port_clk_en_o = clk_en_q;

    // ****************************************************************
    // Fault on access to a gated port
    // ****************************************************************
    dspcg_port_fault #(
        .PORTS(PORTS)
    ) u_fault (
        .clk_sys_i     (clk_sys_i),
        .reset_n_i     (reset_n_i),
        .port_req_i    (port_req_i),
        .port_sel_i    (port_sel_i),
        .port_clk_en_i (clk_en_q),
        .port_fault_o  (port_fault_o),
        .port_ok_o     (port_ok_o),
        .fault_count_o (fault_count)
    );

endmodule // dspcg_clock_gate

`default_nettype wire

// *** logic/dspcg_map.vh ***
// Register offsets, field positions and reset values of the deep-sleep port clock gate
`ifndef DSPCG_MAP_VH
`define DSPCG_MAP_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define DSPCG_OFS_RUN_PORT_EN      12'h108
`define DSPCG_OFS_SLEEP_PORT_EN    12'h118
`define DSPCG_OFS_DEEP_PORT_EN     12'h128
`define DSPCG_OFS_RUN_CLOCK_CONFIG 12'h060
`define DSPCG_OFS_MODE_STATUS      12'h130
`define DSPCG_OFS_FAULT_STATUS     12'h134

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define DSPCG_PORT_BITS            8
`define DSPCG_AUTO_GATING_BIT      27
`define DSPCG_PORT_EN_RESET        8'h00
`define DSPCG_CONFIG_RESET         1'b0

// ****************************************************************
// Operating modes
// ****************************************************************
`define DSPCG_MODE_RUN             2'h0
`define DSPCG_MODE_SLEEP           2'h1
`define DSPCG_MODE_DEEP            2'h2

`endif

// *** logic/dspcg_port_fault.v ***
// Per-port bus fault decision for accesses aimed at ports
`timescale 1ns/100ps
`default_nettype none

module dspcg_port_fault #(
    parameter PORTS = 8
) (
    // Clock and reset
    input  wire             clk_sys_i,
    input  wire             reset_n_i,
    // Port access request
    input  wire             port_req_i,
    input  wire [2:0]       port_sel_i,
    // Effective port clocks
    input  wire [PORTS-1:0] port_clk_en_i,
    // Fault answer
    output reg              port_fault_o,
    output reg              port_ok_o,
    output reg  [7:0]       fault_count_o
);

    // ****************************************************************
    // Answer one cycle after the request
    // ****************************************************************
    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            port_fault_o  <= 1'b0;
            port_ok_o     <= 1'b0;
            fault_count_o <= 8'h00;
        end else begin
            port_fault_o <= port_req_i & ~port_clk_en_i[port_sel_i];
            port_ok_o    <= port_req_i & port_clk_en_i[port_sel_i];
            if (port_req_i && !port_clk_en_i[port_sel_i] && fault_count_o != 8'hff) begin
                fault_count_o <= fault_count_o + 8'h01;
            end
        end
    end

endmodule // dspcg_port_fault

`default_nettype wire

// *** tb/dspcg_clock_gate_assertions.sv ***
// Port assertions of the deep-sleep port clock gate
`timescale 1ns/100ps
`default_nettype none
module dspcg_clock_gate_chk #(parameter PORTS = 8) (
    input wire logic clk_sys_i, reset_n_i, reg_wr_i, reg_rd_i, port_req_i,
    input wire logic sleep_req_i, deep_sleep_req_i, port_fault_o, port_ok_o,
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i, reg_rdata_o,
    input wire logic [PORTS-1:0] port_clk_en_o,
    input wire logic [2:0] port_sel_i
);
    // Shadow of the deep, run and auto gating settings
    logic [PORTS-1:0] deep_q, run_q;
    logic auto_q;
    wire run_eff = !auto_q || !(sleep_req_i || deep_sleep_req_i);
    always_ff @(posedge clk_sys_i)
        if (!reset_n_i) {deep_q, run_q, auto_q} <= '0;
        else if (reg_wr_i && reg_addr_i == 12'h128) deep_q <= reg_wdata_i[PORTS-1:0];
        else if (reg_wr_i && reg_addr_i == 12'h108) run_q <= reg_wdata_i[PORTS-1:0];
        else if (reg_wr_i && reg_addr_i == 12'h060) auto_q <= reg_wdata_i[27];
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    AST_RST: assert property (disable iff (1'b0) !reset_n_i
        |=> !port_clk_en_o) else $error("enables set");
    AST_FLT: assert property (port_req_i && !port_clk_en_o[port_sel_i]
        |=> port_fault_o && !port_ok_o) else $error("no fault");
    AST_OK: assert property (port_req_i && port_clk_en_o[port_sel_i]
        |=> port_ok_o && !port_fault_o) else $error("no ok");
    AST_IDLE: assert property (!port_req_i
        |=> !port_fault_o && !port_ok_o) else $error("stray answer");
    AST_RDZ: assert property (!reg_rd_i
        |=> reg_rdata_o == '0) else $error("data held");
    AST_RDD: assert property (reg_rd_i && reg_addr_i == 12'h128
        |=> reg_rdata_o == 32'($past(deep_q))) else $error("bad read");
    AST_DEEP: assert property ((deep_sleep_req_i && auto_q && !reg_wr_i)[*3]
        |-> port_clk_en_o == deep_q) else $error("bad deep");
    AST_RUN: assert property ((run_eff && !reg_wr_i)[*3]
        |-> port_clk_en_o == run_q) else $error("bad run");
endmodule // dspcg_clock_gate_chk
`default_nettype wire

// *** tb/tb_dspcg_clock_gate.sv ***
// Self-checking bench of the deep-sleep port clock gate
`timescale 1ns/100ps
`default_nettype none
module tb_dspcg_clock_gate;
    logic clk_sys_i = '0, reset_n_i = '0, reg_wr_i = '0, reg_rd_i = '0, port_req_i = '0;
    logic sleep_req_i = '0, deep_sleep_req_i = '0, port_fault_o, port_ok_o;
    logic [11:0] reg_addr_i = '0;
    logic [11:0] ofs [6] = '{12'h128, 12'h7fc, 12'h108, 12'h118, 12'h060, 12'h134};
    logic [31:0] reg_wdata_i = '0, reg_rdata_o, q, mdl [4096] = '{default: '0};
    logic [7:0] port_clk_en_o, e;
    logic [2:0] port_sel_i = '0;
    int mismatches = 0, n_checks = 0, nf = 0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    dspcg_clock_gate #(.PORTS(8)) dspcg_clock_gate_i (.*);
    task automatic chk(input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} <= {w, !w, a, d};
        @(posedge clk_sys_i);
        {reg_wr_i, reg_rd_i} <= 2'h0;
        #1 q = reg_rdata_o;
        if (w) mdl[a] = d;
    endtask
    // Enables per mode, then every port asked back to back, then fault count and mode read back
    task automatic settle();
        repeat (3) @(posedge clk_sys_i);
        q = mdl[!mdl['h060][27] ? 'h108 : deep_sleep_req_i ? 'h128 : sleep_req_i ? 'h118 : 'h108];
        e = q[7:0];
        #1 chk(port_clk_en_o, e);
        for (int s = 0; s < 9; s++) begin
            @(posedge clk_sys_i);
            {port_req_i, port_sel_i} <= {s < 8, 3'(s)};
            #1 if (s > 0) begin
                chk({port_fault_o, port_ok_o}, {!e[s-1], e[s-1]});
                nf += int'(!e[s-1]);
            end
        end
        bus(1'b0, 12'h134, '0);
        chk(q, 32'(nf));
        bus(1'b0, 12'h130, '0);
        chk(q, deep_sleep_req_i ? 32'h2 : sleep_req_i ? 32'h1 : 32'h0);
    endtask
    task automatic end_of_test();
        $display("%0d checks, %0d mismatches", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // The run needs about 2 us
    initial begin
        #20000 mismatches++;
        end_of_test();
    end
    initial begin
        q = $urandom(85412);
        repeat (2) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        for (int r = 0; r < 2; r++) begin
            foreach (ofs[i]) begin
                bus(1'b0, ofs[i], '0);
                chk(q, '0);
            end
            settle();
            bus(1'b1, 12'h108, $urandom());
            bus(1'b1, 12'h118, $urandom());
            bus(1'b0, 12'h108, '0);
            chk(q, mdl['h108][7:0]);
            bus(1'b0, 12'h118, '0);
            chk(q, mdl['h118][7:0]);
            for (int m = 0; m < 8; m++) begin
                if (m % 4 == 0) begin
                    bus(1'b1, 12'h060, 32'(m / 4) << 27);
                    bus(1'b0, 12'h060, '0);
                    chk(q, mdl['h060]);
                end
                bus(1'b0, 12'h128, '0);
                chk(q, mdl['h128][7:0]);
                bus(1'b1, 12'h128, {q[31:8], 8'($urandom())});
                bus(1'b0, 12'h128, '0);
                chk(q, mdl['h128][7:0]);
                @(posedge clk_sys_i);
                {deep_sleep_req_i, sleep_req_i} <= 2'(m);
                settle();
            end
            $display("pass %0d done", r);
            @(posedge clk_sys_i);
            reset_n_i <= 1'b0;
            repeat (2) @(posedge clk_sys_i);
            reset_n_i <= 1'b1;
            mdl = '{default: '0};
            nf = 0;
        end
        end_of_test();
    end
endmodule // tb_dspcg_clock_gate
bind dspcg_clock_gate dspcg_clock_gate_chk #(.PORTS(PORTS)) dspcg_chk_i (
    .clk_sys_i        (clk_sys_i),
    .reset_n_i        (reset_n_i),
    .reg_wr_i         (reg_wr_i),
    .reg_rd_i         (reg_rd_i),
    .port_req_i       (port_req_i),
    .sleep_req_i      (sleep_req_i),
    .deep_sleep_req_i (deep_sleep_req_i),
    .port_fault_o     (port_fault_o),
    .port_ok_o        (port_ok_o),
    .reg_addr_i       (reg_addr_i),
    .reg_wdata_i      (reg_wdata_i),
    .reg_rdata_o      (reg_rdata_o),
    .port_clk_en_o    (port_clk_en_o),
    .port_sel_i       (port_sel_i)
);
`default_nettype wire
